// >>> design/host_read_port_mux.sv
// Read path of the 8-bit host port: source select, byte choice and bus drive.
`timescale 1ns/1ps
`default_nettype none
module host_read_port_mux (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        write_n,
   input  wire logic        read_n,
   input  wire logic [2:0]  addr,
   input  wire logic [7:0]  data_in,
   output logic      [7:0]  data_out,
   output logic             data_oe,
   input  wire logic [15:0] i_word,
   input  wire logic [15:0] q_word,
   input  wire logic [15:0] mag_word,
   input  wire logic [15:0] phase_word,
   input  wire logic [15:0] freq_word,
   input  wire logic [23:0] level_word,
   input  wire logic        gain_overflow,
   input  wire logic [3:0]  gain_shift,
   input  wire logic [10:0] gain_mantissa,
   input  wire logic [15:0] timing_word,
   input  wire logic [2:0]  fifo_depth,
   input  wire logic        fifo_empty,
   input  wire logic        fifo_full,
   input  wire logic        buffer_threshold_n,
   input  wire logic        level_done_a
);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers. Strobes rest high, so they reset high.

   logic [1:0]  strobe_s;
   logic [11:0] bus_s;
   logic        write_n_s;
   logic        read_n_s;
   logic [2:0]  addr_s;
   logic [7:0]  data_s;
   logic        level_done_s;
   logic        write_n_prev;
   logic        read_n_prev;
   logic        write_rise;
   logic        read_fall;

   pin_sync #(.WIDTH(2), .INIT(64'h3)) u_strobe_sync (
      .clock  (clock),
      .reset  (reset),
      .pin    ({write_n, read_n}),
      .synced (strobe_s)
   );

   pin_sync #(.WIDTH(12), .INIT(64'h0)) u_bus_sync (
      .clock  (clock),
      .reset  (reset),
      .pin    ({addr, data_in}),
      .synced (bus_s)
   );

   // Level detector completion comes from another clock, so it is synchronised too.
   pin_sync #(.WIDTH(1), .INIT(64'h0)) u_done_sync (
      .clock  (clock),
      .reset  (reset),
      .pin    (level_done_a),
      .synced (level_done_s)
   );

   assign write_n_s = strobe_s[1];
   assign read_n_s  = strobe_s[0];
   assign addr_s    = bus_s[10:8];
   assign data_s    = bus_s[7:0];

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         write_n_prev <= 1'b1;
         read_n_prev  <= 1'b1;
      end else begin
         write_n_prev <= write_n_s;
         read_n_prev  <= read_n_s;
      end
   end

   assign write_rise = write_n_s && !write_n_prev;
   assign read_fall  = !read_n_s && read_n_prev;

   ////////////////////////////////////////////////////////////////////////////////
   // Write side: read code and gain capture.

   host_read_pkg::read_code_t read_code;
   logic [15:0]               gain_snap;
   logic [15:0]               gain_live;

   // Bus sampled one synchroniser delay later still holds, as the host keeps hold time.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         read_code <= host_read_pkg::read_code_t'(host_read_pkg::READ_CODE_RESET);
      end else if (write_rise && addr_s == host_read_pkg::ADDR_READ_SELECT) begin
         read_code <= host_read_pkg::read_code_t'(data_s[host_read_pkg::CODE_BITS-1:0]);
      end
   end

   assign gain_live = {gain_mantissa[7:0], gain_overflow, gain_shift, gain_mantissa[10:8]};

   // The gain moves on its own, so it is frozen only on the capture command.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         gain_snap <= host_read_pkg::GAIN_RESET;
      end else if (write_rise && addr_s == host_read_pkg::ADDR_DEST_ADDRESS
                   && data_s == host_read_pkg::DEST_GAIN_CAPTURE) begin
         gain_snap <= {gain_live[7:0], gain_live[15:8]};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read side: status, byte choice and bus drive.

   logic [6:0]  status;
   logic [15:0] gain_word;
   read_sel_if  sel ();

   assign status    = {fifo_depth, fifo_empty, fifo_full, buffer_threshold_n, level_done_s};
   assign gain_word = {gain_snap[15:8], gain_snap[7:0]};
   assign sel.code  = read_code;
   assign sel.addr  = addr_s;

   read_byte_select u_select (
      .sel         (sel),
      .i_word      (i_word),
      .q_word      (q_word),
      .mag_word    (mag_word),
      .phase_word  (phase_word),
      .freq_word   (freq_word),
      .level_word  (level_word),
      .gain_word   (gain_word),
      .timing_word (timing_word),
      .status      (status)
   );

   host_read_pkg::port_state_t port_state;

   // The byte is latched at the falling edge so it stays still for the whole strobe.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         port_state <= host_read_pkg::port_idle;
         data_out   <= host_read_pkg::IDLE_BYTE;
         data_oe    <= 1'b0;
      end else begin
         unique case (port_state)
            host_read_pkg::port_idle: begin
               if (read_fall) begin
                  port_state <= host_read_pkg::port_driving;
                  data_out   <= sel.data;
                  data_oe    <= 1'b1;
               end
            end
            host_read_pkg::port_driving: begin
               if (read_n_s) begin
                  port_state <= host_read_pkg::port_idle;
                  data_oe    <= 1'b0;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   sequence read_start;
      read_fall && port_state == host_read_pkg::port_idle;
   endsequence

   sequence select_write;
      write_rise && addr_s == host_read_pkg::ADDR_READ_SELECT;
   endsequence

   sequence gain_capture;
      write_rise && addr_s == host_read_pkg::ADDR_DEST_ADDRESS && data_s == host_read_pkg::DEST_GAIN_CAPTURE;
   endsequence

   sequence status_read;
      read_start ##0 (addr_s == host_read_pkg::ADDR_STATUS);
   endsequence

   sequence strobe_released;
      data_oe && read_n_s;
   endsequence

   a_code_capture: assert property (select_write |=> read_code == $past(data_s[2:0]))
      else $error("read code not taken from data bits 2:0");
   a_status_override: assert property (status_read |=> data_out == {1'b0, $past(status)})
      else $error("status byte not returned at address 7");
   a_drive_on_read: assert property (read_start |=> data_oe)
      else $error("bus not driven after read strobe fell");
   a_release_idle: assert property (strobe_released |=> !data_oe)
      else $error("bus still driven with read strobe high");
   a_iq_select: assert property (read_start ##0 (read_code == 3'h0 && addr_s == 3'h3)
                                 |=> data_out == $past(q_word[15:8]))
      else $error("quadrature high byte wrong");
   a_polar_select: assert property (read_start ##0 (read_code == 3'h1 && addr_s == 3'h1)
                                    |=> data_out == $past(mag_word[15:8]))
      else $error("magnitude high byte wrong");
   a_freq_select: assert property (read_start ##0 (read_code == 3'h2 && addr_s == 3'h0)
                                   |=> data_out == $past(freq_word[7:0]))
      else $error("frequency low byte wrong");
   a_level_select: assert property (read_start ##0 (read_code == 3'h4 && addr_s == 3'h2)
                                    |=> data_out == $past(level_word[23:16]))
      else $error("level detector top byte wrong");
   a_timing_live: assert property (read_start ##0 (read_code == 3'h5 && addr_s == 3'h3)
                                   |=> data_out == $past(timing_word[15:8]))
      else $error("timing error high byte wrong");
   a_gain_layout: assert property (gain_capture |=> gain_snap[15:8] == {$past(gain_overflow),
                                   $past(gain_shift), $past(gain_mantissa[10:8])})
      else $error("gain high byte not oeeeemmm");
   a_hold_strobe: assert property (data_oe && !read_n_s |=> $stable(data_out) && data_oe)
      else $error("driven byte changed during strobe");

   ////////////////////////////////////////////////////////////////////////////////
   // Byte choice per read code. Spare codes below address 7 and spare addresses read as zero, so a host
   // that selects a wrong source sees a quiet bus rather than a stale byte.

   a_iq_low: assert property (read_start ##0 (read_code == 3'h0 && addr_s == 3'h0)
                              |=> data_out == $past(i_word[7:0]))
      else $error("in-phase low byte wrong");
   a_quad_low: assert property (read_start ##0 (read_code == 3'h0 && addr_s == 3'h2)
                                |=> data_out == $past(q_word[7:0]))
      else $error("quadrature low byte wrong");
   a_phase_select: assert property (read_start ##0 (read_code == 3'h1 && addr_s == 3'h3)
                                    |=> data_out == $past(phase_word[15:8]))
      else $error("phase high byte wrong");
   a_freq_high: assert property (read_start ##0 (read_code == 3'h2 && addr_s == 3'h1)
                                 |=> data_out == $past(freq_word[15:8]))
      else $error("frequency high byte wrong");
   a_freq_unused: assert property (read_start ##0 (read_code == 3'h2 && addr_s == 3'h2)
                                   |=> data_out == host_read_pkg::IDLE_BYTE)
      else $error("frequency spare address not zero");
   a_level_low: assert property (read_start ##0 (read_code == 3'h4 && addr_s == 3'h0)
                                 |=> data_out == $past(level_word[7:0]))
      else $error("level detector low byte wrong");
   a_gain_low_read: assert property (read_start ##0 (read_code == 3'h5 && addr_s == 3'h0)
                                     |=> data_out == $past(gain_snap[7:0]))
      else $error("gain low byte read wrong");
   a_gain_high_read: assert property (read_start ##0 (read_code == 3'h5 && addr_s == 3'h1)
                                      |=> data_out == $past(gain_snap[15:8]))
      else $error("gain high byte read wrong");
   a_spare_code: assert property (read_start ##0 (read_code == 3'h3 && addr_s != 3'h7)
                                  |=> data_out == host_read_pkg::IDLE_BYTE)
      else $error("spare read code not zero");

   ////////////////////////////////////////////////////////////////////////////////
   // Status byte fields. Address 7 bypasses the read code, so these hold whatever
   // code was written last.

   a_status_depth: assert property (status_read |=> data_out[6:4] == $past(fifo_depth))
      else $error("status fill depth wrong");
   a_status_empty: assert property (status_read |=> data_out[3] == $past(fifo_empty))
      else $error("status empty bit wrong");
   a_status_full: assert property (status_read |=> data_out[2] == $past(fifo_full))
      else $error("status full bit wrong");
   a_status_threshold: assert property (status_read |=> data_out[1] == $past(buffer_threshold_n))
      else $error("status threshold bit wrong");
   a_status_done: assert property (status_read |=> data_out[0] == $past(level_done_s))
      else $error("status level_done_a bit wrong");

   ////////////////////////////////////////////////////////////////////////////////
   // Held state. A change at any other edge would hand the host a source or a gain
   // that it never asked for.

   a_code_holds: assert property (!(write_rise && addr_s == host_read_pkg::ADDR_READ_SELECT)
                                  |=> $stable(read_code))
      else $error("read code changed without an address 5 write");
   a_gain_holds: assert property (!(write_rise && addr_s == host_read_pkg::ADDR_DEST_ADDRESS
                                    && data_s == host_read_pkg::DEST_GAIN_CAPTURE) |=> $stable(gain_snap))
      else $error("gain snapshot moved without a capture");
   a_gain_mantissa: assert property (gain_capture |=> gain_snap[7:0] == $past(gain_mantissa[7:0]))
      else $error("gain low byte not mantissa bits");
   a_idle_quiet: assert property (port_state == host_read_pkg::port_idle |-> !data_oe)
      else $error("bus driven while port idle");

   // Reset itself is watched here, so the default disable is switched off for this one.
   a_reset_clears: assert property (disable iff (1'b0) reset |=> !data_oe && data_out == host_read_pkg::IDLE_BYTE
                                    && read_code == host_read_pkg::READ_CODE_RESET
                                    && gain_snap == host_read_pkg::GAIN_RESET)
      else $error("reset left the port busy");
endmodule
`default_nettype wire

// >>> design/host_read_pkg.sv
// Shared constants and types of the host read port.
package host_read_pkg;

   localparam logic [2:0] ADDR_DEST_ADDRESS = 3'h4;
   localparam logic [2:0] ADDR_READ_SELECT  = 3'h5;
   localparam logic [2:0] ADDR_STATUS       = 3'h7;

   localparam logic [7:0] DEST_GAIN_CAPTURE = 8'h0a;

   localparam logic [2:0] BYTE_0 = 3'h0;
   localparam logic [2:0] BYTE_1 = 3'h1;
   localparam logic [2:0] BYTE_2 = 3'h2;
   localparam logic [2:0] BYTE_3 = 3'h3;

   localparam int         CODE_BITS       = 3;
   localparam int         SYNC_STAGES     = 2;
   localparam int         STATUS_BITS     = 7;
   localparam logic [2:0] READ_CODE_RESET = 3'h0;
   localparam logic [7:0] IDLE_BYTE       = 8'h00;
   localparam logic [15:0] GAIN_RESET     = 16'h0000;

   typedef enum logic [2:0] {
      code_iq          = 3'b000,
      code_polar       = 3'b001,
      code_freq        = 3'b010,
      code_spare_3     = 3'b011,
      code_level       = 3'b100,
      code_gain_timing = 3'b101,
      code_spare_6     = 3'b110,
      code_spare_7     = 3'b111
   } read_code_t;

   typedef enum logic [0:0] {
      port_idle    = 1'b0,
      port_driving = 1'b1
   } port_state_t;

endpackage

// >>> design/read_sel_if.sv
// Read selection carried between the port top and its byte chooser.
`timescale 1ns/1ps
`default_nettype none
interface read_sel_if;
   host_read_pkg::read_code_t code;
   logic [2:0]                addr;
   logic [7:0]                data;

   modport owner   (output code, output addr, input data);
   modport chooser (input code, input addr, output data);
endinterface
`default_nettype wire

// >>> design/pin_sync.sv
// Two-stage synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int          WIDTH = 1,
   parameter logic [63:0] INIT  = 64'h0
) (
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] synced
);
   logic [WIDTH-1:0] first;

   generate
      if (WIDTH < 1 || WIDTH > 64) begin : g_bad_width
         $error("pin_sync width must be 1 to 64");
      end
   endgenerate

   // The first stage may go metastable, so only the second stage reads it.
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         first  <= INIT[WIDTH-1:0];
         synced <= INIT[WIDTH-1:0];
      end else begin
         first  <= pin;
         synced <= first;
      end
   end
endmodule
`default_nettype wire

// >>> design/read_byte_select.sv
// Byte chooser that maps read code and read address to one byte.
`timescale 1ns/1ps
`default_nettype none
module read_byte_select (
   read_sel_if.chooser          sel,
   input  wire logic [15:0]     i_word,
   input  wire logic [15:0]     q_word,
   input  wire logic [15:0]     mag_word,
   input  wire logic [15:0]     phase_word,
   input  wire logic [15:0]     freq_word,
   input  wire logic [23:0]     level_word,
   input  wire logic [15:0]     gain_word,
   input  wire logic [15:0]     timing_word,
   input  wire logic [6:0]      status
);
   // Low byte at even addresses, high byte at the next odd one.
   function automatic logic [7:0] pair_byte(input logic [15:0] low, input logic [15:0] high,
                                            input logic [2:0] addr);
      logic [7:0] b;
      b = host_read_pkg::IDLE_BYTE;
      unique case (addr)
         host_read_pkg::BYTE_0: b = low[7:0];
         host_read_pkg::BYTE_1: b = low[15:8];
         host_read_pkg::BYTE_2: b = high[7:0];
         host_read_pkg::BYTE_3: b = high[15:8];
         default:               b = host_read_pkg::IDLE_BYTE;
      endcase
      return b;
   endfunction

   always_comb begin
      sel.data = host_read_pkg::IDLE_BYTE;
      if (sel.addr == host_read_pkg::ADDR_STATUS) begin
         sel.data = {1'b0, status};
      end else begin
         unique case (sel.code)
            host_read_pkg::code_iq:          sel.data = pair_byte(i_word, q_word, sel.addr);
            host_read_pkg::code_polar:       sel.data = pair_byte(mag_word, phase_word, sel.addr);
            host_read_pkg::code_freq:        sel.data = pair_byte(freq_word, 16'h0000, sel.addr);
            host_read_pkg::code_level: begin
               unique case (sel.addr)
                  host_read_pkg::BYTE_0: sel.data = level_word[7:0];
                  host_read_pkg::BYTE_1: sel.data = level_word[15:8];
                  host_read_pkg::BYTE_2: sel.data = level_word[23:16];
                  default:               sel.data = host_read_pkg::IDLE_BYTE;
               endcase
            end
            host_read_pkg::code_gain_timing: sel.data = pair_byte(gain_word, timing_word, sel.addr);
            default:                         sel.data = host_read_pkg::IDLE_BYTE;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> sim/host_cpu_model.sv
// Host processor model that runs write and read cycles on the 8-bit port.
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
   input  wire logic       clock,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe,
   output logic            write_n,
   output logic            read_n,
   output logic [2:0]      addr,
   output logic [7:0]      data_in
);
   logic [7:0] host_data = 8'h00;
   logic       host_en   = 1'b0;
   logic [7:0] float_val = 8'h5a;

   initial begin
      write_n = 1'b1;
      read_n  = 1'b1;
      addr    = 3'h0;
   end

   // A released bus has no pull, so it wanders rather than holding its last value.
   always @(posedge clock) begin
      float_val <= ~float_val;
   end

   assign data_in = host_en ? host_data : (data_oe ? data_out : float_val);

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wait_edges(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Address and data stay put past the rising strobe edge.
   task automatic write_cycle(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      addr      <= a;
      host_data <= d;
      host_en   <= 1'b1;
      wait_edges(4);
      write_n <= 1'b0;
      wait_edges(4);
      write_n <= 1'b1;
      wait_edges(4);
      host_en <= 1'b0;
      wait_edges(4);
   endtask

   // Strobe returns high and the address settles before each byte.
   task automatic read_cycle(input logic [2:0] a, output logic [7:0] d, output logic on, output logic off);
      @(posedge clock);
      addr <= a;
      wait_edges(4);
      read_n <= 1'b0;
      wait_edges(5);
      d  = data_out;
      on = data_oe;
      read_n <= 1'b1;
      wait_edges(5);
      off = data_oe;
   endtask
endmodule
`default_nettype wire

// >>> sim/test_host_read_port_mux.sv
// Self-checking bench of the host read port against a reference model.
`timescale 1ns/1ps
`default_nettype none
module test_host_read_port_mux;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   wire logic   write_n;
   wire logic   read_n;
   wire logic [2:0] addr;
   wire logic [7:0] data_in;
   logic [7:0]  data_out;
   logic        data_oe;
   logic [15:0] i_word = '0, q_word = '0, mag_word = '0, phase_word = '0;
   logic [15:0] freq_word = '0, timing_word = '0, gain_cap = '0;
   logic [23:0] level_word = '0;
   logic [10:0] gain_mantissa = '0;
   logic [3:0]  gain_shift = '0;
   logic [2:0]  fifo_depth = '0;
   logic        gain_overflow = 1'b0, fifo_empty = 1'b0, fifo_full = 1'b0;
   logic        buffer_threshold_n = 1'b1, level_done_a = 1'b0;
   logic [31:0] seed = 32'h33b18ba0;
   int          errors = 0, checks_done = 0, cycles = 0;
   int          model_code = 0;
   logic [7:0]  expect_q[$];

   always #2 clock = ~clock;

   host_read_port_mux dut (.clock, .reset, .write_n, .read_n, .addr, .data_in, .data_out, .data_oe,
      .i_word, .q_word, .mag_word, .phase_word, .freq_word, .level_word, .gain_overflow, .gain_shift,
      .gain_mantissa, .timing_word, .fifo_depth, .fifo_empty, .fifo_full, .buffer_threshold_n, .level_done_a);

   host_cpu_model host (.clock, .data_out, .data_oe, .write_n, .read_n, .addr, .data_in);

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [7:0] exp_byte(input int code, input int a);
      logic [15:0] lo_w;
      logic [15:0] hi_w;
      if (a == 7) return {1'b0, fifo_depth, fifo_empty, fifo_full, buffer_threshold_n, level_done_a};
      lo_w = 16'h0000;
      hi_w = 16'h0000;
      case (code)
         0: begin lo_w = i_word; hi_w = q_word; end
         1: begin lo_w = mag_word; hi_w = phase_word; end
         2: lo_w = freq_word;
         4: begin lo_w = level_word[15:0]; hi_w = {8'h00, level_word[23:16]}; end
         5: begin lo_w = gain_cap; hi_w = timing_word; end
         default: ;
      endcase
      case (a)
         0: return lo_w[7:0];
         1: return lo_w[15:8];
         2: return hi_w[7:0];
         3: return hi_w[15:8];
         default: return 8'h00;
      endcase
   endfunction

   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic check_bit(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic new_sources();
      logic [31:0] t;
      t = rnd();
      @(posedge clock);
      {i_word, q_word} <= rnd();
      {mag_word, phase_word} <= rnd();
      {freq_word, timing_word} <= rnd();
      {level_word, fifo_depth, fifo_empty, fifo_full, buffer_threshold_n, level_done_a, gain_overflow} <= rnd();
      {gain_shift, gain_mantissa} <= t[14:0];
   endtask

   // The model follows the host's writes, so reset and ignored writes are covered too.
   task automatic read_check(input int a);
      logic [7:0] got;
      logic       on;
      logic       off;
      expect_q.push_back(exp_byte(model_code, a));
      host.read_cycle(a[2:0], got, on, off);
      check_byte("read byte", expect_q.pop_front(), got);
      check_bit("bus driven", 1'b1, on);
      check_bit("bus released", 1'b0, off);
   endtask

   task automatic host_write(input logic [2:0] a, input logic [7:0] d);
      host.write_cycle(a, d);
      if (a == 3'h5) model_code = int'(d[2:0]);
      if (a == 3'h4 && d == 8'h0a) gain_cap = {gain_overflow, gain_shift, gain_mantissa};
   endtask

   // The ceiling is several times the expected run, so only a hang reaches it.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         report_and_stop();
      end
   end

   initial begin
      logic [31:0] rv;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      repeat (4) @(posedge clock);
      read_check(0);
      $display("test reset_default done");
      for (int r = 0; r < 3; r++) begin
         new_sources();
         host_write(3'h4, 8'h0a);
         new_sources();
         host_write(3'h4, 8'h0b);
         for (int c = 0; c < 8; c++) begin
            rv = rnd();
            host_write(3'h5, {rv[7:3], c[2:0]});
            host_write(3'h6, rv[15:8]);
            for (int a = 0; a < 8; a++) begin
               read_check(a);
            end
         end
         $display("test round %0d done", r);
      end
      // A reset in mid-run must drop the read code and the gain snapshot.
      @(posedge clock);
      reset <= 1'b1;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      model_code = 0;
      gain_cap = 16'h0000;
      repeat (4) @(posedge clock);
      read_check(0);
      host_write(3'h5, 8'h05);
      read_check(0);
      read_check(1);
      $display("test mid_reset done");
      report_and_stop();
   end
endmodule
`default_nettype wire
